// File: hdl/ncs_sequencer.v
`timescale 1ns/100ps
`include "ncs_defines.vh"
module ncs_sequencer
#(
    parameter PROG_CYC  = `NCS_PROG_CYC,
    parameter ERASE_CYC = `NCS_ERASE_CYC
)
(
    clk_sys,
    srst,
    cmd_we,
    addr_we,
    data_we,
    data_re,
    io_in,
    wp_n,
    io_out_ff,
    io_oe_ff,
    ready_busy_out_ff,
    ready_busy_oe_ff,
    fail_inject
);
    input  wire        clk_sys;
    input  wire        srst;
    input  wire        cmd_we;     // Command latch strobe, one cycle
    input  wire        addr_we;    // Address latch strobe, one cycle
    input  wire        data_we;    // Data write strobe, one cycle
    input  wire        data_re;    // Data read strobe, one cycle
    input  wire [7:0]  io_in;
    input  wire        wp_n;
    input  wire        fail_inject; // Test hook: next program/erase fails
    output reg  [7:0]  io_out_ff;
    output reg         io_oe_ff;
    output reg         ready_busy_out_ff; // Open drain: 1 = released (ready)
    output reg         ready_busy_oe_ff;  // High while pulling busy low

    localparam [2:0] S_INIT   = 3'd0;
    localparam [2:0] S_IDLE   = 3'd1;
    localparam [2:0] S_LOAD   = 3'd2;
    localparam [2:0] S_PROG   = 3'd3;
    localparam [2:0] S_ERASE  = 3'd4;
    localparam [2:0] S_FETCH  = 3'd5;
    localparam [2:0] S_READ   = 3'd6;

    // Busy loads cut to the timer width on purpose
    localparam [21:0] INIT_CYC = `NCS_INIT_CYC;
    localparam [21:0] READ_CYC = `NCS_READ_CYC;

    reg [2:0]  state_ff;
    reg [21:0] timer_ff;
    reg        fail_ff;
    reg        stat_mode_ff;   // Status is shown on reads
    reg        in_read_ff;     // Read mode was entered
    reg [2:0]  addr_cnt_ff;
    reg [`NCS_COL_W-1:0] col_ff;
    reg [7:0]  rd_col_ff;

    wire [7:0] mem_rd;
    wire       busy = (state_ff == S_INIT) || (state_ff == S_PROG) ||
                      (state_ff == S_ERASE) || (state_ff == S_FETCH);

    function [7:0] status_byte;
        input b_busy;
        input b_fail;
        input b_wpn;
        begin
            status_byte = 8'h00;
            status_byte[`NCS_ST_FAIL]   = b_fail;
            status_byte[`NCS_ST_RDY_PB] = ~b_busy;
            status_byte[`NCS_ST_RDY_DC] = ~b_busy;
            status_byte[`NCS_ST_NWP]    = b_wpn;
        end
    endfunction

    ncs_page_mem u_mem
    (
        .clk_sys (clk_sys),
        .wr_en   (data_we && state_ff == S_LOAD),
        .wr_addr (col_ff[7:0]),
        .wr_data (io_in),
        .rd_addr (rd_col_ff),
        .rd_data (mem_rd)
    );

    // Main command sequencer
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_ff     <= S_INIT;
            timer_ff     <= INIT_CYC;
            fail_ff      <= 1'b0;
            stat_mode_ff <= 1'b0;
            in_read_ff   <= 1'b0;
            addr_cnt_ff  <= 3'd0;
            col_ff       <= 16'h0000;
            rd_col_ff    <= 8'h00;
        end
        else if (cmd_we && io_in == `NCS_CMD_RESET)
        begin
            state_ff     <= S_IDLE;
            timer_ff     <= 22'h000000;
            stat_mode_ff <= 1'b0;
            in_read_ff   <= 1'b0;
            addr_cnt_ff  <= 3'd0;
        end
        else if (cmd_we && (io_in == `NCS_CMD_STATUS || io_in == `NCS_CMD_STATUS2))
        begin
            stat_mode_ff <= 1'b1;
            // A pending load is dropped; status output is the new mode
            if (state_ff == S_LOAD)
                state_ff <= S_IDLE;
        end
        else if (busy)
        begin
            // Write protect kills a running program or erase
            if (!wp_n && (state_ff == S_PROG || state_ff == S_ERASE))
            begin
                state_ff <= S_IDLE;
                fail_ff  <= 1'b1;
            end
            else if (timer_ff == 22'h000000)
            begin
                state_ff <= (state_ff == S_FETCH) ? S_READ : S_IDLE;
                rd_col_ff <= col_ff[7:0];
            end
            else
                timer_ff <= timer_ff - 22'h000001;
        end
        else if (cmd_we)
        begin
            addr_cnt_ff <= 3'd0;
            case (io_in)
                `NCS_CMD_READ:
                begin
                    // Resume from the interrupted column, no new address
                    if (stat_mode_ff && in_read_ff && state_ff == S_READ)
                        stat_mode_ff <= 1'b0;
                    else
                    begin
                        state_ff     <= S_IDLE;
                        stat_mode_ff <= 1'b0;
                        in_read_ff   <= 1'b0;
                    end
                end
                `NCS_CMD_READ_GO:
                begin
                    state_ff   <= S_FETCH;
                    timer_ff   <= READ_CYC;
                    in_read_ff <= 1'b1;
                end
                `NCS_CMD_SDIN:
                begin
                    state_ff     <= S_LOAD;
                    stat_mode_ff <= 1'b0;
                end
                `NCS_CMD_COLCHG:
                    state_ff <= (state_ff == S_LOAD) ? S_LOAD : S_IDLE;
                `NCS_CMD_PROG, `NCS_CMD_PROG_MP, `NCS_CMD_PROG_CACHE:
                begin
                    if (state_ff == S_LOAD && wp_n)
                    begin
                        state_ff <= S_PROG;
                        timer_ff <= PROG_CYC[21:0];
                        fail_ff  <= fail_inject;
                    end
                    else
                    begin
                        state_ff <= S_IDLE;
                        fail_ff  <= ~wp_n;
                    end
                end
                `NCS_CMD_ERASE2:
                begin
                    if (wp_n)
                    begin
                        state_ff <= S_ERASE;
                        timer_ff <= ERASE_CYC[21:0];
                        fail_ff  <= fail_inject;
                    end
                    else
                        fail_ff <= 1'b1;
                end
                default:
                begin
                    // Abandon any pending load without writing
                    state_ff     <= S_IDLE;
                    stat_mode_ff <= 1'b0;
                    in_read_ff   <= 1'b0;
                end
            endcase
        end
        else if (addr_we)
        begin
            // Only five cycles count; a sixth is dropped
            if (addr_cnt_ff < `NCS_ADDR_CYCLES)
            begin
                addr_cnt_ff <= addr_cnt_ff + 3'd1;
                if (addr_cnt_ff == 3'd0)
                    col_ff[7:0] <= io_in;
                else if (addr_cnt_ff == 3'd1)
                    col_ff[15:8] <= io_in;
            end
        end
        else if (data_we && state_ff == S_LOAD)
            col_ff <= col_ff + 16'h0001;
        else if (data_re && state_ff == S_READ && !stat_mode_ff)
            rd_col_ff <= rd_col_ff + 8'h01;
    end

    // Outputs, all registered
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            io_out_ff         <= 8'h00;
            io_oe_ff          <= 1'b0;
            ready_busy_out_ff <= 1'b0;
            ready_busy_oe_ff  <= 1'b1;
        end
        else
        begin
            ready_busy_out_ff <= ~busy;
            ready_busy_oe_ff  <= busy;
            io_oe_ff          <= data_re;
            if (stat_mode_ff)
                io_out_ff <= status_byte(busy, fail_ff, wp_n);
            else
                io_out_ff <= mem_rd;
        end
    end
endmodule // ncs_sequencer

// File: hdl/ncs_defines.vh
`ifndef NCS_DEFINES_VH
`define NCS_DEFINES_VH
// Command codes
`define NCS_CMD_READ      8'h00
`define NCS_CMD_READ_GO   8'h30
`define NCS_CMD_SDIN      8'h80
`define NCS_CMD_COLCHG    8'h85
`define NCS_CMD_PROG      8'h10
`define NCS_CMD_PROG_MP   8'h11
`define NCS_CMD_PROG_CACHE 8'h15
`define NCS_CMD_ERASE1    8'h60
`define NCS_CMD_ERASE2    8'hd0
`define NCS_CMD_STATUS    8'h70
`define NCS_CMD_STATUS2   8'h71
`define NCS_CMD_RESET     8'hff
// Status bit positions
`define NCS_ST_FAIL       0
`define NCS_ST_RDY_PB     5
`define NCS_ST_RDY_DC     6
`define NCS_ST_NWP        7
// Address
`define NCS_ADDR_CYCLES   3'd5
`define NCS_COL_W         16
// Busy timing, in cycles of the 50 ns clock
`define NCS_CLK_NS        50
`define NCS_INIT_NS       1000
`define NCS_INIT_CYC      ((`NCS_INIT_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`define NCS_READ_NS       25000
`define NCS_READ_CYC      ((`NCS_READ_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`define NCS_PROG_NS       300000
`define NCS_PROG_CYC      (`NCS_PROG_NS / `NCS_CLK_NS)
`define NCS_ERASE_NS      3500000
`define NCS_ERASE_CYC     (`NCS_ERASE_NS / `NCS_CLK_NS)
`endif

// File: hdl/ncs_page_mem.v
`timescale 1ns/100ps
// Page register store; read data registered
module ncs_page_mem
(
    clk_sys,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input  wire        clk_sys;
    input  wire        wr_en;
    input  wire [7:0]  wr_addr;
    input  wire [7:0]  wr_data;
    input  wire [7:0]  rd_addr;
    output reg  [7:0]  rd_data;

    reg [7:0] mem [0:255];

    // Old data on a same-address read, read registered
    always @(posedge clk_sys)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule // ncs_page_mem

// File: bench/ncs_seq_properties.sv
`timescale 1ns/100ps
// Watches the sequencer ports for busy-line and mode-order faults
module ncs_seq_properties
(
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       cmd_we,
    input wire logic       data_re,
    input wire logic [7:0] io_in,
    input wire logic       wp_n,
    input wire logic [7:0] io_out_ff,
    input wire logic       io_oe_ff,
    input wire logic       ready_busy_out_ff,
    input wire logic       ready_busy_oe_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic st_ff;
    logic sd_ff;
    logic pe_ff;
    // Mode trackers; every command updates them so a stale flag cannot mask a fault
    always @(posedge clk_sys)
    begin
        st_ff <= !srst && (cmd_we ? (io_in == 8'h70 || io_in == 8'h71) : st_ff);
        sd_ff <= !srst && (cmd_we ? (io_in == 8'h80 || (sd_ff && io_in == 8'h85)) : sd_ff);
        pe_ff <= !srst && (cmd_we ? (io_in inside {8'h10, 8'h11, 8'h15, 8'hd0})
                                  : pe_ff && !$rose(ready_busy_out_ff));
    end
    init_busy_a: assert property ($fell(srst) |-> ready_busy_oe_ff && !ready_busy_out_ff)
        else $error("busy not shown after reset");
    init_hold_a: assert property ($fell(srst) |-> !ready_busy_out_ff [*8])
        else $error("init busy too short");
    rb_pair_a: assert property (ready_busy_oe_ff != ready_busy_out_ff)
        else $error("busy drive and level disagree");
    busy_cause_a: assert property ($fell(ready_busy_out_ff) |->
        $past(cmd_we) || $past(cmd_we, 2) || $past(cmd_we, 3))
        else $error("busy without a command");
    reset_cmd_a: assert property (cmd_we && io_in == 8'hff |-> ##[1:4] ready_busy_out_ff)
        else $error("reset command did not end busy");
    wp_abort_a: assert property (pe_ff && !wp_n |-> ##[1:4] ready_busy_out_ff)
        else $error("protect did not abort");
    status_wp_a: assert property (st_ff && data_re && $stable(wp_n) |=>
        io_oe_ff && io_out_ff[7] == $past(wp_n))
        else $error("status byte wrong");
    drop_prog_a: assert property (sd_ff && cmd_we && ready_busy_out_ff &&
        !(io_in inside {8'h80, 8'h85, 8'h10, 8'h11, 8'h15, 8'hff}) |=> ready_busy_out_ff [*5])
        else $error("dropped program still ran");
endmodule // ncs_seq_properties

bind ncs_sequencer ncs_seq_properties i_props (.clk_sys(clk_sys), .srst(srst), .cmd_we(cmd_we),
    .data_re(data_re), .io_in(io_in), .wp_n(wp_n), .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff),
    .ready_busy_out_ff(ready_busy_out_ff), .ready_busy_oe_ff(ready_busy_oe_ff));

// File: bench/ncs_host_model.sv
`timescale 1ns/100ps
// Host controller: one-cycle strobes launched just after an edge
module ncs_host_model
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] io_out_ff,
    output logic            cmd_we,
    output logic            addr_we,
    output logic            data_we,
    output logic            data_re,
    output logic      [7:0] io_in
);
    initial
    begin
        {cmd_we, addr_we, data_we, data_re} = 4'h0;
        io_in = 8'h00;
    end
    // Kind 0 command, 1 address, 2 data; released bus shows the inverse, never stale data
    task put(input logic [1:0] k, input logic [7:0] b);
        @(posedge clk_sys);
        #1;
        io_in = b;
        {cmd_we, addr_we, data_we} = {k == 2'd0, k == 2'd1, k == 2'd2};
        @(posedge clk_sys);
        #1;
        {cmd_we, addr_we, data_we} = 3'h0;
        io_in = ~b;
    endtask
    // Byte lands on the edge that takes the read strobe
    task rd(output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        data_re = 1'b1;
        @(posedge clk_sys);
        #1;
        data_re = 1'b0;
        d = io_out_ff;
    endtask
endmodule // ncs_host_model

// File: bench/test_nand_command_usage_rules.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_nand_command_usage_rules;
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic       wp_n = 1'b1;
    logic       fail_inject = 1'b0;
    logic [7:0] d;
    wire        cmd_we, addr_we, data_we, data_re, io_oe_ff, rb_out, rb_oe;
    wire  [7:0] io_in, io_out_ff;
    wire        rb_line = rb_oe ? 1'b0 : 1'b1; // Open drain with pull-up
    int         bad_count = 0;
    int         tests_run = 0;
    int         n;
    // Rows: erase, wp_n, fail_inject, expected fail bit
    logic [3:0] rows [5] = '{4'b1100, 4'b1111, 4'b0001, 4'b0111, 4'b0100};
    always #25 clk_sys = ~clk_sys;
    // Short busy counts keep the run brief
    ncs_sequencer #(.PROG_CYC(20), .ERASE_CYC(30)) i_dut (.clk_sys(clk_sys), .srst(srst),
        .cmd_we(cmd_we), .addr_we(addr_we), .data_we(data_we), .data_re(data_re), .io_in(io_in),
        .wp_n(wp_n), .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff), .ready_busy_out_ff(rb_out),
        .ready_busy_oe_ff(rb_oe), .fail_inject(fail_inject));
    ncs_host_model i_host (.clk_sys(clk_sys), .io_out_ff(io_out_ff), .cmd_we(cmd_we),
        .addr_we(addr_we), .data_we(data_we), .data_re(data_re), .io_in(io_in));
    task close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded poll; the bench still issues status and reset commands while busy
    task wait_rdy(input int lim);
        repeat (3) @(posedge clk_sys);
        #1;
        n = 0;
        while (rb_line !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            $display("[FAIL] t=%0t busy %h limit %h", $time, n, lim);
        end
    endtask
    // Page 0 of block blk, lowest page first; a column change and a sixth address ride along
    task prog(input logic [7:0] blk, input logic [7:0] go = 8'h10);
        i_host.put(2'd0, 8'h80);
        repeat (2) i_host.put(2'd1, 8'h00);
        i_host.put(2'd1, 8'h00);
        repeat (2) i_host.put(2'd1, blk);
        i_host.put(2'd1, 8'h55);
        for (int i = 0; i < 2; i++) i_host.put(2'd2, 8'ha0 + 8'(i));
        i_host.put(2'd0, 8'h85);
        i_host.put(2'd1, 8'h02);
        i_host.put(2'd1, 8'h00);
        for (int i = 2; i < 4; i++) i_host.put(2'd2, 8'ha0 + 8'(i));
        i_host.put(2'd0, go);
    endtask
    task erase(input logic [7:0] blk);
        i_host.put(2'd0, 8'h60);
        i_host.put(2'd1, 8'h00);
        repeat (2) i_host.put(2'd1, blk);
        i_host.put(2'd0, 8'hd0);
    endtask
    task status(input logic [7:0] c = 8'h70);
        i_host.put(2'd0, c);
        i_host.rd(d);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK(rb_line, 1'b0)
        srst = 1'b0;
        status;
        `CHK(d[5], 1'b0)
        wait_rdy(60);
        // Each row owns a fresh block, so a block that failed is never touched again
        foreach (rows[r])
        begin
            wp_n = rows[r][2];
            fail_inject = rows[r][1];
            if (rows[r][3]) erase(8'(r + 1));
            else prog(8'(r + 1), rows[r][1] ? 8'h11 : 8'h10);
            wait_rdy(100);
            status;
            `CHK(d[0], rows[r][0])
            `CHK(d[7:5], {rows[r][2], 2'b11})
        end
        wp_n = 1'b1;
        fail_inject = 1'b0;
        // Read from column 1, break in with status and read it twice, then resume
        i_host.put(2'd0, 8'h00);
        i_host.put(2'd1, 8'h01);
        repeat (4) i_host.put(2'd1, 8'h00);
        i_host.put(2'd0, 8'h30);
        wait_rdy(700);
        i_host.rd(d);
        `CHK(d, 8'ha1)
        `CHK(d != 8'h00, 1'b1)
        status;
        i_host.rd(d);
        `CHK(d[7:5], 3'b111)
        i_host.put(2'd0, 8'h00);
        i_host.rd(d);
        `CHK(d, 8'ha2)
        // Foreign command after serial input drops the load; a later 10h starts nothing
        i_host.put(2'd0, 8'h80);
        i_host.put(2'd0, 8'h70);
        i_host.put(2'd0, 8'h10);
        repeat (4)
        begin
            @(posedge clk_sys);
            #1;
            `CHK(rb_line, 1'b1)
        end
        // Protect dropped mid-program aborts and reports fail
        prog(8'h06, 8'h15);
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK(rb_line, 1'b0)
        wp_n = 1'b0;
        wait_rdy(6);
        status(8'h71);
        `CHK(d[0], 1'b1)
        wp_n = 1'b1;
        // Reset command mid-erase
        erase(8'h07);
        repeat (5) @(posedge clk_sys);
        i_host.put(2'd0, 8'hff);
        wait_rdy(4);
        `CHK(rb_line, 1'b1)
        close_out;
    end
    initial
    begin
        #(50 * 10000);
        bad_count++;
        close_out;
    end
endmodule // test_nand_command_usage_rules
